// File: rtl/eth_cmp_consts.vh
/*
 Constants of the Ethernet/LLC/SNAP header comparator: register byte
 offsets, field positions, reset values and protocol values.
 Assumes inclusion by bare name from the comparator source.
*/
`ifndef ETH_CMP_CONSTS_VH
`define ETH_CMP_CONSTS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_TAG_PROTOCOL 8'h04
`define REG_TYPE_MATCH 8'h08
`define REG_FLOW 8'h0c
`define REG_STATUS 8'h10

// Control register fields
`define CTRL_TYPE_CMP_EN 0
`define CTRL_BACKBONE_EN 1
`define CTRL_NEXT_CMP_LSB 4
`define CTRL_SIG_OFS_LSB 8
`define CTRL_MASK 32'h00001f73

// Flow register fields: enables then two tag-count bits per flow
`define FLOW_EN_LSB 0
`define FLOW_TAGS_LSB 8

// Reset values
`define CTRL_RST 32'h00000000
`define TAG_PROTOCOL_RST 32'h00008a88
`define TYPE_MATCH_RST 32'h00000000
`define FLOW_RST 32'h00000301

// Protocol values
`define C_TAG_TPID 16'h8100
`define LENGTH_LIMIT 16'h0600
`define LLC_SAP_A 8'haa
`define LLC_SAP_B 8'hab
`define LLC_CTL 8'h03
`define OUI_ALT_LOW 8'hf8
`define ANY_TAG_COUNT 2'h3

// Field lengths in bytes, last index of each field
`define ADDR_LAST 4'hb
`define ITAG_LAST 4'h3
`define LLC_LAST 4'h2
`define SNAP_LAST 4'h4

// AXI4-Lite responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/eth_header_comparator.v
/*
 One Ethernet/LLC/SNAP header comparator stage of a packet analyzer
 engine, with its AXI4-Lite configuration slave.
 Assumes byte-serial frame data on aclk from the engine aligner, and
 an engine controller that gives the header start to the second stage.
*/
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "eth_cmp_consts.vh"

module eth_header_comparator #(
    parameter INSTANCE = 0,
    parameter FLOWS = 8,
    parameter [15:0] ITAG_TPID = 16'h88e7
) (
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Frame bytes from the aligner
    input wire in_valid,
    input wire [7:0] in_data,
    input wire in_sof,
    input wire in_eof,
    // Header start from the engine controller
    input wire start_valid,
    input wire [7:0] start_offset,
    // Result to the controller and next stage
    output reg result_valid,
    output reg result_match,
    output reg result_nop,
    output reg [7:0] next_offset,
    output reg [FLOWS-1:0] flow_hits,
    output wire [2:0] next_comparator,
    output wire [4:0] sig_offset
);

    ////////////////////////////////////////////////////////////////////
    // Parser states
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_SEEK = 8'h02;
    localparam [7:0] ST_ADDR = 8'h04;
    localparam [7:0] ST_TYPE = 8'h08;
    localparam [7:0] ST_TAG = 8'h10;
    localparam [7:0] ST_ITAG = 8'h20;
    localparam [7:0] ST_LLC = 8'h40;
    localparam [7:0] ST_SNAP = 8'h80;

    reg [31:0] ctrl;
    reg [31:0] tag_protocol;
    reg [31:0] type_match;
    reg [31:0] flow_cfg;
    reg [31:0] sel_old;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [7:0] state;
    reg [3:0] cnt;
    reg [7:0] pos;
    reg [7:0] hdr_start;
    reg [7:0] fld;
    reg [1:0] tags;
    reg snap_seen;
    reg is_length;
    reg eof_seen;
    wire [7:0] cur;
    wire [15:0] word;
    wire [15:0] s_tpid;
    wire backbone;
    wire type_cmp_en;
    wire is_tag;
    wire [FLOWS-1:0] hit_now;
    wire do_write;
    wire [7:0] rel_offset;
    wire [31:0] merged;

    ////////////////////////////////////////////////////////////////////
    // Configuration taps, one shared set for all flows
    assign s_tpid = tag_protocol[15:0];
    assign type_cmp_en = ctrl[`CTRL_TYPE_CMP_EN];
    assign backbone = (INSTANCE == 0) && ctrl[`CTRL_BACKBONE_EN];
    assign next_comparator = ctrl[`CTRL_NEXT_CMP_LSB+2:`CTRL_NEXT_CMP_LSB];
    assign sig_offset = ctrl[`CTRL_SIG_OFS_LSB+4:`CTRL_SIG_OFS_LSB];
    // Frame byte position and the two most recent bytes
    assign cur = in_sof ? 8'h00 : pos;
    assign word = {fld, in_data};
    assign is_tag = (word == `C_TAG_TPID) || (word == s_tpid);
    assign rel_offset = cur - hdr_start + 8'h01;

    // Flow hits on the number of leading tags seen
    genvar g;
    generate
        for (g = 0; g < FLOWS; g = g + 1) begin : flow_cmp
            wire [1:0] want;
            assign want = flow_cfg[`FLOW_TAGS_LSB+2*g+1:`FLOW_TAGS_LSB+2*g];
            assign hit_now[g] = flow_cfg[`FLOW_EN_LSB+g]
                && (want == `ANY_TAG_COUNT || want == tags);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data in either order
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;

    // Merge write data into the addressed register by byte strobes
    function [31:0] strobe_merge;
        input [31:0] old;
        input [31:0] nv;
        input [3:0] strb;
        integer i;
        begin
            strobe_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) strobe_merge[8*i+:8] = nv[8*i+:8];
            end
        end
    endfunction

    // Current value of the register being written
    always @* begin
        case (aw_addr_q)
            `REG_CTRL: sel_old = ctrl;
            `REG_TAG_PROTOCOL: sel_old = tag_protocol;
            `REG_TYPE_MATCH: sel_old = type_match;
            `REG_FLOW: sel_old = flow_cfg;
            default: sel_old = 32'h00000000;
        endcase
    end

    assign merged = strobe_merge(sel_old, w_data_q, w_strb_q);
    // Write channel capture, register update and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            ctrl <= `CTRL_RST;
            tag_protocol <= `TAG_PROTOCOL_RST;
            type_match <= `TYPE_MATCH_RST;
            flow_cfg <= `FLOW_RST;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                case (aw_addr_q)
                    `REG_CTRL: ctrl <= merged & `CTRL_MASK
                        & ~(INSTANCE != 0 ? 32'h2 : 32'h0);
                    `REG_TAG_PROTOCOL: tag_protocol <= {16'h0000, merged[15:0]};
                    `REG_TYPE_MATCH: type_match <= {16'h0000, merged[15:0]};
                    `REG_FLOW: flow_cfg <= {8'h00, merged[23:0]};
                    `REG_STATUS: bresp <= `RESP_OKAY;
                    default: bresp <= `RESP_SLVERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side: answer one cycle after the address is taken
    assign arready = !rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (araddr)
                `REG_CTRL: rdata <= ctrl;
                `REG_TAG_PROTOCOL: rdata <= tag_protocol;
                `REG_TYPE_MATCH: rdata <= type_match;
                `REG_FLOW: rdata <= flow_cfg;
                // Last result: offset, tags, length frame, match, nop
                `REG_STATUS: rdata <= {19'h00000, result_nop, result_match,
                    is_length, tags, next_offset};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Header start: fixed at zero in the first copy
    always @(posedge aclk) begin
        if (!aresetn || INSTANCE == 0) begin
            hdr_start <= 8'h00;
        end else if (start_valid) begin
            hdr_start <= start_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Header parser; each finish reports once per frame
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            pos <= 8'h00;
            fld <= 8'h00;
            tags <= 2'h0;
            snap_seen <= 1'b0;
            is_length <= 1'b0;
            eof_seen <= 1'b0;
            result_valid <= 1'b0;
            result_match <= 1'b0;
            result_nop <= 1'b0;
            next_offset <= 8'h00;
            flow_hits <= {FLOWS{1'b0}};
        end else begin
            result_valid <= 1'b0;
            eof_seen <= in_valid && in_eof;
            // Frame ended before the header was complete
            if (eof_seen && state != ST_IDLE) begin
                state <= ST_IDLE;
                result_valid <= 1'b1;
                result_match <= 1'b0;
                result_nop <= 1'b1;
                flow_hits <= {FLOWS{1'b0}};
            end
            if (in_valid) begin
                fld <= in_data;
                if (in_sof) begin
                    pos <= 8'h01;
                end else if (pos != 8'hff) begin
                    pos <= pos + 8'h01;
                end
                if (in_sof || state == ST_SEEK) begin
                    tags <= 2'h0;
                    snap_seen <= 1'b0;
                    is_length <= 1'b0;
                    cnt <= 4'h1;
                    state <= (cur == hdr_start) ? ST_ADDR : ST_SEEK;
                end else begin
                    case (state)
                        ST_ADDR: begin
                            cnt <= cnt + 4'h1;
                            if (cnt == `ADDR_LAST) begin
                                state <= ST_TYPE;
                                cnt <= 4'h0;
                            end
                        end
                        ST_TYPE: begin
                            cnt <= 4'h1;
                            if (cnt != 4'h0) begin
                                cnt <= 4'h0;
                                // Last type field decides the protocol
                                if (snap_seen) begin
                                    finish(!is_tag && word >= `LENGTH_LIMIT);
                                end else if (is_tag) begin
                                    if (tags < (backbone ? 2'h1 : 2'h2)) begin
                                        tags <= tags + 2'h1;
                                        state <= ST_TAG;
                                    end else begin
                                        finish(1'b0);
                                    end
                                end else if (backbone && word == ITAG_TPID) begin
                                    state <= ST_ITAG;
                                end else if (word < `LENGTH_LIMIT) begin
                                    is_length <= 1'b1;
                                    state <= ST_LLC;
                                end else begin
                                    finish(!type_cmp_en
                                        || word == type_match[15:0]);
                                end
                            end
                        end
                        ST_TAG: begin
                            cnt <= cnt + 4'h1;
                            if (cnt == 4'h1) begin
                                cnt <= 4'h0;
                                state <= ST_TYPE;
                            end
                        end
                        ST_ITAG: begin
                            cnt <= cnt + 4'h1;
                            if (cnt == `ITAG_LAST) begin
                                finish(1'b1);
                            end
                        end
                        ST_LLC: begin
                            cnt <= cnt + 4'h1;
                            if (cnt == `LLC_LAST) begin
                                cnt <= 4'h0;
                                state <= ST_SNAP;
                                if (in_data != `LLC_CTL) begin
                                    finish(1'b0);
                                end
                            end else if (in_data != `LLC_SAP_A
                                && in_data != `LLC_SAP_B) begin
                                finish(1'b0);
                            end
                        end
                        ST_SNAP: begin
                            cnt <= cnt + 4'h1;
                            if ((cnt < 4'h2 && in_data != 8'h00)
                                || (cnt == 4'h2 && in_data != 8'h00
                                && in_data != `OUI_ALT_LOW)) begin
                                finish(1'b0);
                            end else if (cnt == `SNAP_LAST) begin
                                snap_seen <= 1'b1;
                                cnt <= 4'h0;
                                if (is_tag) begin
                                    state <= ST_TAG;
                                end else begin
                                    finish(word >= `LENGTH_LIMIT);
                                end
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end
        end
    end
    // Report the result of this header and stop parsing the frame
    task finish;
        input ok;
        begin
            state <= ST_IDLE;
            result_valid <= 1'b1;
            result_match <= ok && (|hit_now);
            result_nop <= !(ok && (|hit_now));
            next_offset <= rel_offset;
            flow_hits <= hit_now;
        end
    endtask

endmodule // eth_header_comparator

`default_nettype wire

// File: tb/engine_ctrl_model.sv
/* Model of the engine controller facing one comparator copy.
   Assumes eight flows and the bench choosing each header start. */
`timescale 1ns/1ps
`default_nettype none
module engine_ctrl_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] hdr_start,
    output wire logic start_valid,
    output wire logic [7:0] start_offset,
    input wire logic result_valid,
    input wire logic result_match,
    input wire logic [7:0] next_offset,
    input wire logic [7:0] flow_hits,
    output var logic [7:0] n_res,
    output var logic [8:0] got,
    output var logic [7:0] got_hits
);
// Header start held ahead of and through each frame
assign start_valid = aresetn;
assign start_offset = hdr_start;
// Collects each stage result and counts them
always @(posedge aclk) begin
    if (!aresetn) begin
        n_res <= 8'h00;
    end else if (result_valid) begin
        n_res <= n_res + 8'h01;
        got <= {result_match, next_offset};
        got_hits <= flow_hits;
    end
end
endmodule // engine_ctrl_model
`default_nettype wire

// File: tb/eth_cmp_asserts.sv
/* Port checker for one header comparator copy.
   Assumes a bind onto every copy, one clock and a low-active reset. */
`timescale 1ns/1ps
`default_nettype none
module eth_cmp_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic result_valid,
    input wire logic result_match,
    input wire logic result_nop,
    input wire logic [7:0] next_offset,
    input wire logic [2:0] next_comparator,
    input wire logic [4:0] sig_offset
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////
// Register bus handshakes
a_read_next: assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after address");
a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped before ready");
a_read_block: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before ready");
a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
a_write_cause: assert property ($rose(bvalid) |-> $past(!awready && !wready))
    else $error("write answer without both halves taken");
a_cfg_write: assert property (!$rose(bvalid) |->
    $stable({next_comparator, sig_offset}))
    else $error("configuration outputs moved without a write");
////////////////////////////////////////////////////////////////////////
// Result reporting
a_result_pulse: assert property (result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");
a_nop_inverse: assert property (result_valid |-> result_nop != result_match)
    else $error("no-operation flag not inverse of match");
a_result_hold: assert property (!result_valid |->
    $stable(result_match) && $stable(next_offset))
    else $error("result changed without strobe");
a_offset_legal: assert property (result_valid && result_match |->
    next_offset inside {8'h0e, 8'h12, 8'h16, 8'h1a, 8'h1e})
    else $error("next protocol offset not a header length");
c_match: cover property (result_valid && result_match);
c_nop: cover property (result_valid && result_nop);
c_wr_err: cover property (bvalid && bresp == 2'h2);
endmodule // eth_cmp_asserts
bind eth_header_comparator eth_cmp_asserts u_eth_cmp_asserts (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .result_valid(result_valid), .result_match(result_match),
    .result_nop(result_nop), .next_offset(next_offset),
    .next_comparator(next_comparator), .sig_offset(sig_offset));
`default_nettype wire

// File: tb/tb_top.sv
/* Bench: two comparator copies, controller models and an AXI master.
   Assumes the checker is bound onto each copy. */
`timescale 1ns/1ps
`default_nettype none
`include "eth_cmp_consts.vh"
module tb_top;
localparam logic [15:0] ITAG = 16'h88e7;
localparam logic [8:0] XT [0:11] = '{9'h10e, 9'h112, 9'h116, 9'h116,
    9'h11e, 9'h11a, 9'h0, 9'h0, 9'h0, 9'h0, 9'h112, 9'h116};
logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, in_valid = 1'b0;
logic in_sof = 1'b0, in_eof = 1'b0;
logic [7:0] awaddr = 8'h00, araddr = 8'h00, in_data = 8'h00, hs1 = 8'h00;
logic [31:0] wdata = 32'h0, rs = 32'h344e, rd1;
logic [3:0] wstrb = 4'hf;
logic [15:0] ety, stp;
logic [7:0] hexp;
logic [7:0] fr[$];
int n_errors = 0, checks = 0;
wire awready, wready, bvalid, arready, rvalid, rv0, rm0, rn0, rv1, rm1;
wire rn1, sv0, sv1;
wire [1:0] bresp, rresp;
wire [31:0] rdata, r1data;
wire [7:0] no0, no1, fh0, fh1, st0, st1, n0, n1, h0, h1;
wire [8:0] g0, g1;
wire [2:0] nc0;
wire [4:0] so0;
// First copy owns the bus answers
eth_header_comparator #(.INSTANCE(0), .ITAG_TPID(ITAG))
u_eth_header_comparator (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eof(in_eof), .start_valid(sv0), .start_offset(st0),
    .result_valid(rv0), .result_match(rm0), .result_nop(rn0),
    .next_offset(no0), .flow_hits(fh0), .next_comparator(nc0),
    .sig_offset(so0));
// Second copy shares bus and frame stream
eth_header_comparator #(.INSTANCE(1), .ITAG_TPID(ITAG))
u_eth_header_comparator_1 (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(),
    .rdata(r1data), .rresp(), .rvalid(), .rready(rready),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eof(in_eof), .start_valid(sv1), .start_offset(st1),
    .result_valid(rv1), .result_match(rm1), .result_nop(rn1),
    .next_offset(no1), .flow_hits(fh1), .next_comparator(),
    .sig_offset());
engine_ctrl_model u_engine_ctrl_model (.aclk(aclk), .aresetn(aresetn),
    .hdr_start(hs1), .start_valid(sv0), .start_offset(st0),
    .result_valid(rv0), .result_match(rm0), .next_offset(no0),
    .flow_hits(fh0), .n_res(n0), .got(g0), .got_hits(h0));
engine_ctrl_model u_engine_ctrl_model_1 (.aclk(aclk), .aresetn(aresetn),
    .hdr_start(hs1), .start_valid(sv1), .start_offset(st1),
    .result_valid(rv1), .result_match(rm1), .next_offset(no1),
    .flow_hits(fh1), .n_res(n1), .got(g1), .got_hits(h1));
// Clock, 40 ns period
always #20 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////
// Xorshift byte source
function automatic logic [7:0] rb();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
endfunction
// Expected {match, offset}; a copy without backbone sees the I-tag as type
function automatic logic [8:0] ex(input int k, input logic pbb);
    return (k > 9 && !pbb) ? XT[k] - 9'h4 : XT[k];
endfunction
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
        n_errors++;
        $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
endtask
task end_sim();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
task tmo(input int n);
    if (n >= 50) begin
        n_errors++;
        $display("unexpected bus wait: expected answer, seen none");
        end_sim();
    end
endtask
////////////////////////////////////////////////////////////////////////
// Bus write and read
task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    tmo(n);
    chk("write response", er, bresp);
endtask
task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        n++;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    rd1 = r1data;
    tmo(n);
    chk("read data", ed, rdata);
    chk("read response", er, rresp);
endtask
////////////////////////////////////////////////////////////////////////
// Frame building, 16-bit fields first byte high
task p16(input logic [15:0] v);
    fr.push_back(v[15:8]);
    fr.push_back(v[7:0]);
endtask
task ls(input logic [7:0] ctl, input logic [7:0] oui);
    p16({8'h00, rb() & 8'h7f});
    fr.push_back(rb() & 8'h01 | 8'haa);
    fr.push_back(8'hab);
    fr.push_back(ctl);
    p16(16'h0000);
    fr.push_back(oui);
endtask
task mk(input int k);
    int i;
    fr.delete();
    for (i = 0; i < 12; i++) fr.push_back(rb());
    ety = {8'h08, rb()};
    if (k inside {2, 4, 7, 11}) p16(stp);
    if (k inside {2, 4, 7, 11}) p16({rb(), rb()});
    if (k inside {1, 2, 4, 7}) p16({`C_TAG_TPID});
    if (k inside {1, 2, 4, 7}) p16({rb(), rb()});
    if (k == 7) p16(`C_TAG_TPID);
    if (k inside {3, 4, 5}) ls(8'h03, rb() > 8'h7f ? 8'hf8 : 8'h00);
    if (k == 6) ls(8'h03, 8'h01);
    if (k == 8) ls(8'h04, 8'h00);
    if (k == 5) p16({`C_TAG_TPID});
    if (k == 5) p16({rb(), rb()});
    if (k > 9) p16(ITAG);
    if (k > 9) repeat (2) p16({rb(), rb()});
    if (k == 9) p16({`C_TAG_TPID});
    if (k < 9) p16(ety);
endtask
task res(input logic [8:0] e, input logic [7:0] c, input logic [7:0] n,
    input logic [8:0] g, input logic [7:0] h);
    if (e !== 9'h1ff) begin
        chk("result count", c + 8'h01, n);
        chk("match", e[8], g[8]);
        if (e[8]) chk("next offset", e[7:0], g[7:0]);
        if (e[8]) chk("flow hits", hexp, h);
    end
endtask
// Sends the frame plus two payload bytes, then checks both copies
task send(input logic [8:0] e0, input logic [8:0] e1);
    int i;
    logic [7:0] c0, c1;
    c0 = n0;
    c1 = n1;
    p16({rb(), rb()});
    for (i = 0; i < fr.size(); i++) begin
        @(posedge aclk);
        in_valid <= 1'b1;
        in_data <= fr[i];
        in_sof <= (i == 0);
        in_eof <= (i == fr.size() - 1);
    end
    @(posedge aclk);
    in_valid <= 1'b0;
    in_eof <= 1'b0;
    repeat (3) @(posedge aclk);
    res(e0, c0, n0, g0, h0);
    res(e1, c1, n1, g1, h1);
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
    int k;
    logic [31:0] d;
    stp = 16'h8a88;
    hexp = 8'h01;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`REG_CTRL, `CTRL_RST, `RESP_OKAY);
    axr(`REG_TAG_PROTOCOL, `TAG_PROTOCOL_RST, `RESP_OKAY);
    axr(`REG_TYPE_MATCH, `TYPE_MATCH_RST, `RESP_OKAY);
    axr(`REG_FLOW, `FLOW_RST, `RESP_OKAY);
    axr(8'h40, 32'h0, `RESP_SLVERR);
    axw(8'h40, 32'hffffffff, `RESP_SLVERR);
    for (k = 0; k < 4; k++) begin
        d = {rb(), rb(), rb(), rb()};
        axw(`REG_CTRL, d, `RESP_OKAY);
        axr(`REG_CTRL, d & `CTRL_MASK, `RESP_OKAY);
        chk("ctrl copy 2", d & `CTRL_MASK & 32'hfffffffd, rd1);
        chk("next comparator", {29'h0, d[6:4]}, {29'h0, nc0});
        chk("signature offset", {27'h0, d[12:8]}, {27'h0, so0});
    end
    wstrb <= 4'h2;
    axw(`REG_CTRL, 32'h0, `RESP_OKAY);
    axr(`REG_CTRL, d & `CTRL_MASK & 32'hffff00ff, `RESP_OKAY);
    wstrb <= 4'hf;
    axw(`REG_CTRL, 32'h0, `RESP_OKAY);
    for (k = 0; k < 20; k++) begin
        mk(k % 10);
        send(ex(k % 10, 1'b0), ex(k % 10, 1'b0));
    end
    axw(`REG_CTRL, 32'h1, `RESP_OKAY);
    mk(0);
    axw(`REG_TYPE_MATCH, {16'h0, ety}, `RESP_OKAY);
    send(9'h10e, 9'h10e);
    mk(0);
    axw(`REG_TYPE_MATCH, {16'h0, ety ^ 16'h0001}, `RESP_OKAY);
    send(9'h000, 9'h000);
    mk(3);
    send(ex(3, 1'b0), ex(3, 1'b0));
    axw(`REG_CTRL, 32'h0, `RESP_OKAY);
    stp = 16'h9100;
    axw(`REG_TAG_PROTOCOL, {16'h0, stp}, `RESP_OKAY);
    mk(2);
    send(ex(2, 1'b0), ex(2, 1'b0));
    stp = 16'h8a88;
    mk(2);
    send(9'h10e, 9'h10e);
    axw(`REG_TAG_PROTOCOL, `TAG_PROTOCOL_RST, `RESP_OKAY);
    axw(`REG_FLOW, 32'h0402, `RESP_OKAY);
    hexp = 8'h02;
    mk(1);
    send(ex(1, 1'b0), ex(1, 1'b0));
    mk(0);
    send(9'h000, 9'h000);
    axw(`REG_FLOW, `FLOW_RST, `RESP_OKAY);
    hexp = 8'h01;
    axw(`REG_CTRL, 32'h2, `RESP_OKAY);
    axr(`REG_CTRL, 32'h2, `RESP_OKAY);
    chk("ctrl copy 2", 32'h0, rd1);
    for (k = 10; k < 12; k++) begin
        mk(k);
        send(ex(k, 1'b1), ex(k, 1'b0));
    end
    axr(`REG_STATUS, 32'h00000916, `RESP_OKAY);
    chk("status copy 2", 32'h00000912, rd1);
    axw(`REG_CTRL, 32'h0, `RESP_OKAY);
    hs1 <= 8'h04;
    mk(0);
    repeat (4) fr.push_front(rb());
    send(9'h1ff, 9'h10e);
    end_sim();
end
endmodule // tb_top
`default_nettype wire
